// ==== logic/crt_pkg.sv ====
package crt_pkg;

	// ------------------------------------------------------------
	// Clock and timing figures
	// ------------------------------------------------------------
	localparam int CLK_NS           = 4;
	localparam int CLK_PS           = 4000;
	localparam int PD_XFER_NS       = 1000;
	localparam int PEDESTAL_NS      = 4000;
	localparam int VDELAY_NS        = 1000;
	localparam int VSHIFT_NS        = 1000;
	localparam int HDELAY_NS        = 200;
	localparam int HPIX_PS          = 25000;
	localparam int RESET_PULSE_PS   = 2500;
	localparam int SHUT_PULSE_NS    = 1000;
	localparam int SHUT_DELAY_NS    = 1000;
	localparam int LINE_DUAL_NS     = 23000;
	localparam int LINE_SINGLE_NS   = 44100;
	localparam int FRAME_QUAD_NS    = 14600000;
	localparam int FRAME_DUAL_NS    = 29100000;
	localparam int FRAME_SINGLE_NS  = 55700000;

	// Least times round up to whole cycles
	localparam int PD_XFER_CYC      = (PD_XFER_NS + CLK_NS - 1) / CLK_NS;
	localparam int PEDESTAL_CYC     = (PEDESTAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int VDELAY_CYC       = (VDELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int VSHIFT_CYC       = (VSHIFT_NS + CLK_NS - 1) / CLK_NS;
	localparam int HDELAY_CYC       = (HDELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int HPIX_CYC         = (HPIX_PS + CLK_PS - 1) / CLK_PS;
	localparam int RESET_PULSE_CYC  = (RESET_PULSE_PS + CLK_PS - 1) / CLK_PS;
	localparam int SHUT_PULSE_CYC   = (SHUT_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SHUT_DELAY_CYC   = (SHUT_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int LINE_DUAL_CYC    = (LINE_DUAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int LINE_SINGLE_CYC  = (LINE_SINGLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int FRAME_QUAD_CYC   = (FRAME_QUAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int FRAME_DUAL_CYC   = (FRAME_DUAL_NS + CLK_NS - 1) / CLK_NS;
	localparam int FRAME_SINGLE_CYC = (FRAME_SINGLE_NS + CLK_NS - 1) / CLK_NS;

	// ------------------------------------------------------------
	// Widths and frame geometry
	// ------------------------------------------------------------
	localparam int TIMER_W          = 24;
	localparam int LINE_W           = 16;
	localparam int CNT_W            = 11;
	localparam int PIXW             = 4;
	localparam int NUM_HREG         = 4;
	localparam logic [CNT_W-1:0] LINES_SHORT  = 11'h278;
	localparam logic [CNT_W-1:0] LINES_LONG   = 11'h4F0;
	localparam logic [CNT_W-1:0] PIXELS_SHORT = 11'h355;
	localparam logic [CNT_W-1:0] PIXELS_LONG  = 11'h6AA;

	// ------------------------------------------------------------
	// Pin levels
	// ------------------------------------------------------------
	localparam logic [1:0] V1_LOW  = 2'h0;
	localparam logic [1:0] V1_MID  = 2'h1;
	localparam logic [1:0] V1_HIGH = 2'h2;
	localparam logic       V_LOW   = 1'b0;
	localparam logic       V_HIGH  = 1'b1;
	localparam logic       H_OFF   = 1'b1;
	localparam logic [1:0] VSTEP_LAST = 2'h3;

	// Horizontal register index
	localparam int HREG_A = 0;
	localparam int HREG_B = 1;
	localparam int HREG_C = 2;
	localparam int HREG_D = 3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_QUAD,
		MODE_DUAL_AB,
		MODE_DUAL_AC,
		MODE_SINGLE
	} crt_mode_t;

	typedef struct packed {
		logic [1:0] phase1;
		logic       phase2;
		logic       phase3;
		logic       phase4;
	} crt_vert_t;

	typedef struct packed {
		logic h1Storage;
		logic h1Barrier;
		logic h2Storage;
		logic h2Barrier;
		logic lastPhase;
		logic resetGate;
	} crt_horiz_t;

	typedef struct packed {
		crt_vert_t                   top;
		crt_vert_t                   bottom;
		crt_horiz_t [NUM_HREG-1:0]   horiz;
		logic                        shutterPulseLevel;
	} crt_pins_t;

endpackage

// ==== logic/crt_hclk_gen.sv ====
`timescale 1ns/1ns
module crt_hclk_gen
	import crt_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Line request
	input  wire logic             start,
	input  wire logic [CNT_W-1:0] pixelCount,
	// Patterns
	output logic                  storagePat,
	output logic                  barrierPat,
	output logic                  resetPat,
	output logic                  done
);

	localparam logic [PIXW-1:0] PIX_LAST  = PIXW'(HPIX_CYC - 1);
	localparam logic [PIXW-1:0] PIX_HALF  = PIXW'(HPIX_CYC / 2);
	localparam logic [PIXW-1:0] RST_WIDTH = PIXW'(RESET_PULSE_CYC);

	logic             busy, next_busy;
	logic [PIXW-1:0]  phase, next_phase;
	logic [CNT_W-1:0] left, next_left;
	logic             next_storagePat, next_resetPat, next_done;

	always_comb begin
		next_busy       = busy;
		next_phase      = phase;
		next_left       = left;
		next_done       = 1'b0;
		next_storagePat = storagePat;
		next_resetPat   = 1'b0;
		if (!busy) begin
			if (start && pixelCount != '0) begin
				next_busy  = 1'b1;
				next_phase = '0;
				next_left  = pixelCount;
			end
		end else begin
			// One pixel period of seven cycles, high for the first three then low for four
			next_storagePat = (phase < PIX_HALF);
			next_resetPat   = (phase < RST_WIDTH);
			if (phase == PIX_LAST) begin
				next_phase = '0;
				next_left  = left - CNT_W'(1);
				if (left == CNT_W'(1)) begin
					next_busy       = 1'b0;
					next_done       = 1'b1;
					next_storagePat = 1'b0;
				end
			end else begin
				next_phase = phase + PIXW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			busy       <= 1'b0;
			phase      <= '0;
			left       <= '0;
			storagePat <= 1'b0;
			resetPat   <= 1'b0;
			done       <= 1'b0;
		end else begin
			busy       <= next_busy;
			phase      <= next_phase;
			left       <= next_left;
			storagePat <= next_storagePat;
			resetPat   <= next_resetPat;
			done       <= next_done;
		end
	end

	assign barrierPat = storagePat;

endmodule

// ==== logic/crt_timing_gen.sv ====
`timescale 1ns/1ns
module crt_timing_gen
	import crt_pkg::*;
#(
	parameter int unsigned LINE_DUAL_MIN    = LINE_DUAL_CYC,
	parameter int unsigned LINE_SINGLE_MIN  = LINE_SINGLE_CYC,
	parameter int unsigned FRAME_QUAD_MIN   = FRAME_QUAD_CYC,
	parameter int unsigned FRAME_DUAL_MIN   = FRAME_DUAL_CYC,
	parameter int unsigned FRAME_SINGLE_MIN = FRAME_SINGLE_CYC
)
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               srst,
	// Frame control
	input  wire logic               run,
	input  wire crt_mode_t          modeSelect,
	input  wire logic               shutterReq,
	input  wire logic [TIMER_W-1:0] exposureCycles,
	// Power and identification status
	input  wire logic               protectionSupplyStable,
	input  wire logic               substrateAbove3V,
	input  wire logic               idReadDone,
	// Sensor pins
	output crt_pins_t               pins,
	// Status and enables
	output logic                    biasEnable,
	output logic                    idCircuitEnable,
	output logic                    frameActive,
	output crt_mode_t               modeActive
);

	// ------------------------------------------------------------
	// Constants at counter width
	// ------------------------------------------------------------
	localparam logic [TIMER_W-1:0] T_PD     = TIMER_W'(PD_XFER_CYC - 1);
	localparam logic [TIMER_W-1:0] T_PED    = TIMER_W'(PEDESTAL_CYC - 1);
	localparam logic [TIMER_W-1:0] T_VDELAY = TIMER_W'(VDELAY_CYC - 1);
	localparam logic [TIMER_W-1:0] T_VSHIFT = TIMER_W'(VSHIFT_CYC - 1);
	localparam logic [TIMER_W-1:0] T_HDELAY = TIMER_W'(HDELAY_CYC - 1);
	localparam logic [TIMER_W-1:0] T_SHUT   = TIMER_W'(SHUT_PULSE_CYC - 1);
	localparam logic [TIMER_W-1:0] T_SDELAY = TIMER_W'(SHUT_DELAY_CYC - 1);
	localparam logic [TIMER_W-1:0] SDELAY   = TIMER_W'(SHUT_DELAY_CYC);
	localparam logic [LINE_W-1:0]  L_DUAL   = LINE_W'(LINE_DUAL_MIN - 1);
	localparam logic [LINE_W-1:0]  L_SINGLE = LINE_W'(LINE_SINGLE_MIN - 1);
	localparam logic [TIMER_W-1:0] F_QUAD   = TIMER_W'(FRAME_QUAD_MIN - 1);
	localparam logic [TIMER_W-1:0] F_DUAL   = TIMER_W'(FRAME_DUAL_MIN - 1);
	localparam logic [TIMER_W-1:0] F_SINGLE = TIMER_W'(FRAME_SINGLE_MIN - 1);

	typedef enum logic [3:0] {
		S_POWER,
		S_IDLE,
		S_SHUT_WAIT,
		S_SHUT,
		S_EXPO,
		S_PED_LEAD,
		S_PD_XFER,
		S_PED_TRAIL,
		S_VDELAY,
		S_VSHIFT,
		S_HDELAY,
		S_HSHIFT,
		S_LINE_PAD,
		S_FRAME_PAD
	} crt_state_t;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	crt_state_t         state, next_state;
	crt_mode_t          next_modeActive;
	logic [TIMER_W-1:0] timer, next_timer;
	logic [TIMER_W-1:0] frameCnt, next_frameCnt;
	logic [LINE_W-1:0]  lineCnt, next_lineCnt;
	logic [CNT_W-1:0]   lineIdx, next_lineIdx;
	logic [1:0]         vStep, next_vStep;
	logic               hStart, next_hStart;
	logic               next_biasEnable, next_idCircuitEnable, next_frameActive;
	crt_pins_t          next_pins;

	// Mode-dependent geometry
	logic [CNT_W-1:0]   linesTotal, pixelsTotal;
	logic [LINE_W-1:0]  lineMin;
	logic [TIMER_W-1:0] frameMin;
	logic [TIMER_W-1:0] expoHold;

	// Horizontal pattern source
	logic hStorage, hBarrier, hReset, hDone;

	crt_hclk_gen u_hclk (
		.clk        (clk),
		.srst       (srst),
		.start      (hStart),
		.pixelCount (pixelsTotal),
		.storagePat (hStorage),
		.barrierPat (hBarrier),
		.resetPat   (hReset),
		.done       (hDone)
	);

	// ------------------------------------------------------------
	// Geometry per mode
	// ------------------------------------------------------------
	always_comb begin
		case (modeActive)
			MODE_QUAD: begin
				linesTotal  = LINES_SHORT;
				pixelsTotal = PIXELS_SHORT;
				lineMin     = L_DUAL;
				frameMin    = F_QUAD;
			end
			MODE_DUAL_AB: begin
				linesTotal  = LINES_LONG;
				pixelsTotal = PIXELS_SHORT;
				lineMin     = L_SINGLE;
				frameMin    = F_DUAL;
			end
			MODE_DUAL_AC: begin
				linesTotal  = LINES_SHORT;
				pixelsTotal = PIXELS_LONG;
				lineMin     = L_DUAL;
				frameMin    = F_DUAL;
			end
			default: begin
				linesTotal  = LINES_LONG;
				pixelsTotal = PIXELS_LONG;
				lineMin     = L_SINGLE;
				frameMin    = F_SINGLE;
			end
		endcase
		// Exposure never shorter than the shutter delay
		expoHold = (exposureCycles > SDELAY) ? exposureCycles - TIMER_W'(1) : T_SDELAY;
	end

	// ------------------------------------------------------------
	// Vertical pattern per step
	// ------------------------------------------------------------
	function automatic crt_vert_t vert_step(input logic [1:0] step);
		crt_vert_t v;
		v.phase1 = (step == 2'h0 || step == 2'h3) ? V1_MID : V1_LOW;
		v.phase2 = (step == 2'h0 || step == 2'h1) ? V_HIGH : V_LOW;
		v.phase3 = (step == 2'h1 || step == 2'h2) ? V_HIGH : V_LOW;
		v.phase4 = (step == 2'h2 || step == 2'h3) ? V_HIGH : V_LOW;
		return v;
	endfunction

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state           = state;
		next_modeActive      = modeActive;
		next_timer           = (timer != '0) ? timer - TIMER_W'(1) : timer;
		next_frameCnt        = frameCnt + TIMER_W'(1);
		next_lineCnt         = lineCnt + LINE_W'(1);
		next_lineIdx         = lineIdx;
		next_vStep           = vStep;
		next_hStart          = 1'b0;
		next_biasEnable      = biasEnable;
		next_idCircuitEnable = idCircuitEnable && !idReadDone;
		case (state)
			S_POWER: begin
				if (protectionSupplyStable && substrateAbove3V) begin
					next_biasEnable = 1'b1;
					next_state      = S_IDLE;
				end
			end
			S_IDLE: begin
				if (run) begin
					next_modeActive = modeSelect;
					next_frameCnt   = '0;
					if (shutterReq && protectionSupplyStable) begin
						next_state = S_SHUT_WAIT;
						next_timer = T_SDELAY;
					end else begin
						next_state = S_PED_LEAD;
						next_timer = T_PED;
					end
				end
			end
			S_SHUT_WAIT: begin
				if (timer == '0) begin
					next_state = S_SHUT;
					next_timer = T_SHUT;
				end
			end
			S_SHUT: begin
				if (timer == '0) begin
					next_state = S_EXPO;
					next_timer = expoHold;
				end
			end
			S_EXPO: begin
				if (timer == '0) begin
					next_state = S_PED_LEAD;
					next_timer = T_PED;
				end
			end
			S_PED_LEAD: begin
				if (timer == '0) begin
					next_state = S_PD_XFER;
					next_timer = T_PD;
				end
			end
			S_PD_XFER: begin
				if (timer == '0) begin
					// Phase one falls here, moving the row and ending integration
					next_state = S_PED_TRAIL;
					next_timer = T_PED;
				end
			end
			S_PED_TRAIL: begin
				if (timer == '0) begin
					next_state   = S_VDELAY;
					next_timer   = T_VDELAY;
					next_lineIdx = '0;
					next_lineCnt = '0;
				end
			end
			S_VDELAY: begin
				if (timer == '0) begin
					next_state = S_VSHIFT;
					next_vStep = '0;
					next_timer = T_VSHIFT;
				end
			end
			S_VSHIFT: begin
				if (timer == '0) begin
					next_vStep = vStep + 2'h1;
					next_timer = T_VSHIFT;
					if (vStep == VSTEP_LAST) begin
						next_state = S_HDELAY;
						next_timer = T_HDELAY;
					end
				end
			end
			S_HDELAY: begin
				if (timer == '0) begin
					next_state  = S_HSHIFT;
					next_hStart = 1'b1;
				end
			end
			S_HSHIFT: begin
				if (hDone) begin
					next_state = S_LINE_PAD;
				end
			end
			S_LINE_PAD: begin
				if (lineCnt >= lineMin) begin
					if (lineIdx == linesTotal - CNT_W'(1)) begin
						next_state = S_FRAME_PAD;
					end else begin
						next_lineIdx = lineIdx + CNT_W'(1);
						next_lineCnt = '0;
						next_state   = S_VDELAY;
						next_timer   = T_VDELAY;
					end
				end
			end
			S_FRAME_PAD: begin
				if (frameCnt >= frameMin) begin
					next_state = S_IDLE;
				end
			end
			default: begin
				next_state = S_POWER;
			end
		endcase
		if (next_frameCnt == '0 && frameCnt != '0 && state != S_IDLE) begin
			next_frameCnt = frameCnt;
		end
		if (next_lineCnt == '0 && lineCnt != '0 && state == S_LINE_PAD && next_state == S_LINE_PAD) begin
			next_lineCnt = lineCnt;
		end
		next_frameActive = (next_state != S_POWER) && (next_state != S_IDLE);
	end

	// ------------------------------------------------------------
	// Pin mapping
	// ------------------------------------------------------------
	crt_vert_t  vertPat;
	crt_horiz_t normalPat, reversePat, offPat;
	crt_horiz_t horizNext [NUM_HREG];

	always_comb begin
		vertPat = vert_step(2'h0);
		if (state == S_VSHIFT) begin
			vertPat = vert_step(vStep);
		end else if (state == S_PD_XFER) begin
			vertPat.phase1 = V1_HIGH;
		end
	end

	assign normalPat  = '{hStorage, hBarrier, !hStorage, !hBarrier, !hStorage, hReset};
	assign reversePat = '{!hStorage, !hBarrier, hStorage, hBarrier, hStorage, hReset};
	assign offPat     = '{H_OFF, H_OFF, H_OFF, H_OFF, H_OFF, H_OFF};

	generate
		for (genvar i = 0; i < NUM_HREG; i++) begin : g_hreg
			always_comb begin
				horizNext[i] = offPat;
				case (i)
					HREG_A: horizNext[i] = normalPat;
					HREG_B: horizNext[i] = (modeActive == MODE_QUAD || modeActive == MODE_DUAL_AB) ?
						normalPat : reversePat;
					HREG_C: horizNext[i] = (modeActive == MODE_QUAD || modeActive == MODE_DUAL_AC) ?
						normalPat : offPat;
					HREG_D: horizNext[i] = (modeActive == MODE_QUAD) ? normalPat : offPat;
					default: horizNext[i] = offPat;
				endcase
			end
		end
	endgenerate

	always_comb begin
		next_pins        = pins;
		next_pins.bottom = vertPat;
		if (modeActive == MODE_QUAD || modeActive == MODE_DUAL_AC) begin
			next_pins.top = vertPat;
		end else begin
			next_pins.top.phase1 = vertPat.phase1;
			next_pins.top.phase2 = vertPat.phase4;
			next_pins.top.phase3 = vertPat.phase3;
			next_pins.top.phase4 = vertPat.phase2;
		end
		for (int k = 0; k < NUM_HREG; k++) begin
			next_pins.horiz[k] = horizNext[k];
		end
		next_pins.shutterPulseLevel = (state == S_SHUT) && protectionSupplyStable;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state           <= S_POWER;
			modeActive      <= MODE_QUAD;
			timer           <= '0;
			frameCnt        <= '0;
			lineCnt         <= '0;
			lineIdx         <= '0;
			vStep           <= '0;
			hStart          <= 1'b0;
			biasEnable      <= 1'b0;
			idCircuitEnable <= 1'b1;
			frameActive     <= 1'b0;
			pins            <= '0;
		end else begin
			state           <= next_state;
			modeActive      <= next_modeActive;
			timer           <= next_timer;
			frameCnt        <= next_frameCnt;
			lineCnt         <= next_lineCnt;
			lineIdx         <= next_lineIdx;
			vStep           <= next_vStep;
			hStart          <= next_hStart;
			biasEnable      <= next_biasEnable;
			idCircuitEnable <= next_idCircuitEnable;
			frameActive     <= next_frameActive;
			pins            <= next_pins;
		end
	end

endmodule

// ==== dv/crt_timing_gen_sva.sv ====
`timescale 1ns/1ns
module crt_timing_gen_sva
	import crt_pkg::*;
(
	// Clock and reset
	input wire logic      clk,
	input wire logic      srst,
	// Power and identification
	input wire logic      protectionSupplyStable,
	input wire logic      substrateAbove3V,
	input wire logic      idReadDone,
	// Outputs watched
	input wire crt_pins_t pins,
	input wire logic      biasEnable,
	input wire logic      idCircuitEnable,
	input wire logic      frameActive,
	input wire crt_mode_t modeActive
);
	logic [31:0] shutRun, next_shutRun, hiRun, next_hiRun, midRun, next_midRun, pixGap, next_pixGap;
	logic        prevActive, next_prevActive, prevStor, next_prevStor;
	logic        hi;
	logic        stor;
	logic        swapMode;
	logic        inFrame;

	assign hi = pins.bottom.phase1 == V1_HIGH;
	assign stor = pins.horiz[HREG_A].h1Storage;
	assign swapMode = modeActive == MODE_DUAL_AB || modeActive == MODE_SINGLE;
	assign inFrame = frameActive && prevActive;

	// ------------------------------------------------------------
	// Run length counters
	// ------------------------------------------------------------
	always_comb begin
		next_shutRun = pins.shutterPulseLevel ? shutRun + 1 : 32'h0;
		next_hiRun = hi ? hiRun + 1 : 32'h0;
		next_midRun = (pins.bottom.phase1 == V1_MID) ? midRun + 1 : 32'h0;
		next_pixGap = (stor && !prevStor) ? 32'h1 : pixGap + 1;
		next_prevActive = frameActive;
		next_prevStor = stor;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			shutRun <= 32'h0;
			hiRun <= 32'h0;
			midRun <= 32'h0;
			pixGap <= 32'hFFFF;
			prevActive <= 1'b0;
			prevStor <= 1'b0;
		end else begin
			shutRun <= next_shutRun;
			hiRun <= next_hiRun;
			midRun <= next_midRun;
			pixGap <= next_pixGap;
			prevActive <= next_prevActive;
			prevStor <= next_prevStor;
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	bias_after_power_a: assert property (
		$rose(biasEnable) |-> $past(protectionSupplyStable) && $past(substrateAbove3V))
		else $error("bias enabled before power ready");
	shutter_gate_a: assert property (
		$rose(pins.shutterPulseLevel) |-> frameActive && ($past(protectionSupplyStable) || $past(protectionSupplyStable, 2)))
		else $error("shutter pulsed without stable protection supply");
	shutter_width_a: assert property (
		$fell(pins.shutterPulseLevel) |-> shutRun >= SHUT_PULSE_CYC)
		else $error("shutter pulse too short");
	xfer_width_a: assert property (
		$fell(hi) |-> hiRun >= PD_XFER_CYC)
		else $error("photodiode transfer too short");
	lead_pedestal_a: assert property (
		$rose(hi) |-> midRun >= PEDESTAL_CYC)
		else $error("leading pedestal too short");
	phase_levels_a: assert property (
		pins.top.phase1 != 2'h3 && pins.bottom.phase1 != 2'h3)
		else $error("phase one at undefined level");
	mode_frozen_a: assert property (
		inFrame |-> $stable(modeActive))
		else $error("mode changed inside a frame");
	top_map_a: assert property (
		inFrame |-> (swapMode ? pins.top == {pins.bottom.phase1, pins.bottom.phase4, pins.bottom.phase3,
			pins.bottom.phase2} : pins.top == pins.bottom))
		else $error("top vertical mapping wrong");
	c_gate_a: assert property (
		inFrame |-> pins.horiz[HREG_C] == (swapMode ? crt_horiz_t'(6'h3F) : pins.horiz[HREG_A]))
		else $error("register c pattern wrong");
	d_gate_a: assert property (
		inFrame |-> pins.horiz[HREG_D] == (modeActive == MODE_QUAD ? pins.horiz[HREG_A] : crt_horiz_t'(6'h3F)))
		else $error("register d pattern wrong");
	pixel_period_a: assert property (
		$rose(stor) |-> pixGap >= HPIX_CYC)
		else $error("pixel period too short");
	id_off_a: assert property (
		idReadDone |-> ##[1:2] !idCircuitEnable)
		else $error("identification circuit left enabled");
endmodule

bind crt_timing_gen crt_timing_gen_sva chk (
	.clk                    (clk),
	.srst                   (srst),
	.protectionSupplyStable (protectionSupplyStable),
	.substrateAbove3V       (substrateAbove3V),
	.idReadDone             (idReadDone),
	.pins                   (pins),
	.biasEnable             (biasEnable),
	.idCircuitEnable        (idCircuitEnable),
	.frameActive            (frameActive),
	.modeActive             (modeActive)
);

// ==== dv/crt_sensor_model.sv ====
`timescale 1ns/1ns
module crt_sensor_model
	import crt_pkg::*;
(
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      srst,
	// Sensor pins
	input  wire crt_pins_t pins,
	// Observed charge movement
	output logic [31:0]    rowCount,
	output logic [31:0]    integCycles
);
	logic [1:0]  prevPh1;
	logic        prevShut;
	logic        integOn;
	logic [31:0] integRun;

	// Sampled mid-cycle, away from the driving edge
	always @(negedge clk) begin
		if (srst) begin
			rowCount = 32'h0;
			integCycles = 32'h0;
			integOn = 1'b0;
			integRun = 32'h0;
		end else begin
			if (prevPh1 == V1_HIGH && pins.bottom.phase1 != V1_HIGH) begin
				rowCount = rowCount + 1;
				if (integOn)
					integCycles = integRun;
				integOn = 1'b0;
			end
			if (prevShut && !pins.shutterPulseLevel) begin
				integOn = 1'b1;
				integRun = 32'h0;
			end
			if (integOn)
				integRun = integRun + 1;
		end
		prevPh1 = pins.bottom.phase1;
		prevShut = pins.shutterPulseLevel;
	end
endmodule

// ==== dv/tb_crt_timing_gen.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin badCount++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_crt_timing_gen
	import crt_pkg::*;
;
	logic               clk, srst, run, shutterReq, protectionSupplyStable, substrateAbove3V, idReadDone;
	crt_mode_t          modeSelect, modeActive;
	logic [TIMER_W-1:0] exposureCycles;
	crt_pins_t          pins;
	logic               biasEnable, idCircuitEnable, frameActive, prevS, prevF, offC, offD;
	logic [31:0]        rowCount, integCycles, seed, shutCnt, run1, pedLead, xferLen, vGap, minVGap, pixGap, minPix;
	crt_vert_t          prevB;
	int                 badCount, checked;

	crt_timing_gen #(.LINE_DUAL_MIN(100), .LINE_SINGLE_MIN(100), .FRAME_QUAD_MIN(1000), .FRAME_DUAL_MIN(1000),
		.FRAME_SINGLE_MIN(1000)) uut (.clk(clk), .srst(srst), .run(run), .modeSelect(modeSelect),
		.shutterReq(shutterReq), .exposureCycles(exposureCycles), .protectionSupplyStable(protectionSupplyStable),
		.substrateAbove3V(substrateAbove3V), .idReadDone(idReadDone), .pins(pins), .biasEnable(biasEnable),
		.idCircuitEnable(idCircuitEnable), .frameActive(frameActive), .modeActive(modeActive));

	crt_sensor_model sensor (.clk(clk), .srst(srst), .pins(pins), .rowCount(rowCount), .integCycles(integCycles));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	function automatic crt_vert_t exp_top(input crt_mode_t m, input crt_vert_t b);
		crt_vert_t t;
		t = b;
		if (m == MODE_DUAL_AB || m == MODE_SINGLE) begin
			t.phase2 = b.phase4;
			t.phase4 = b.phase2;
		end
		return t;
	endfunction

	// ------------------------------------------------------------
	// Pin monitor
	// ------------------------------------------------------------
	always @(negedge clk) begin
		if (srst) begin
			shutCnt = 32'h0;
			run1 = 32'h0;
			vGap = 32'hFFFF;
			minVGap = 32'hFFFF;
			pixGap = 32'hFFFF;
			minPix = 32'hFFFF;
			pedLead = 32'h0;
			xferLen = 32'h0;
		end else begin
			shutCnt = shutCnt + pins.shutterPulseLevel;
			if (pins.bottom.phase1 == prevB.phase1) begin
				run1 = run1 + 1;
			end else begin
				if (prevB.phase1 == V1_MID && pins.bottom.phase1 == V1_HIGH)
					pedLead = run1;
				if (prevB.phase1 == V1_HIGH)
					xferLen = run1;
				run1 = 32'h1;
			end
			if (pins.bottom != prevB) begin
				minVGap = (vGap < minVGap) ? vGap : minVGap;
				vGap = 32'h1;
			end else begin
				vGap = vGap + 1;
			end
			if (pins.horiz[HREG_A].h1Storage && !prevS) begin
				minPix = (pixGap < minPix) ? pixGap : minPix;
				pixGap = 32'h1;
				`CHK(vGap >= HDELAY_CYC, 1'b1)
			end else begin
				pixGap = pixGap + 1;
			end
			if (frameActive && prevF) begin
				offC = modeActive == MODE_DUAL_AB || modeActive == MODE_SINGLE;
				offD = modeActive != MODE_QUAD;
				`CHK(pins.top, exp_top(modeActive, pins.bottom))
				`CHK(pins.horiz[HREG_C], offC ? crt_horiz_t'(6'h3F) : pins.horiz[HREG_A])
				`CHK(pins.horiz[HREG_D], offD ? crt_horiz_t'(6'h3F) : pins.horiz[HREG_A])
			end
		end
		prevB = pins.bottom;
		prevS = pins.horiz[HREG_A].h1Storage;
		prevF = frameActive;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic giveVerdict();
		$display("Counts: checked=%0d mismatches=%0d", checked, badCount);
		if (badCount == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wait_high(input logic sel);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (((sel ? frameActive : biasEnable) !== 1'b1) && n < 60);
		if ((sel ? frameActive : biasEnable) !== 1'b1) begin
			badCount++;
			giveVerdict();
		end
	endtask

	task automatic frame(input crt_mode_t m, input logic shut, input logic prot, input logic [23:0] e);
		logic [31:0] expInteg;
		expInteg = ((e < SHUT_DELAY_CYC) ? SHUT_DELAY_CYC : e) + PEDESTAL_CYC + PD_XFER_CYC;
		@(posedge clk);
		srst <= 1'b1;
		protectionSupplyStable <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		wait_high(1'b0);
		@(posedge clk);
		modeSelect <= m;
		shutterReq <= shut;
		exposureCycles <= e;
		protectionSupplyStable <= prot;
		run <= 1'b1;
		wait_high(1'b1);
		`CHK(modeActive, m)
		@(posedge clk);
		run <= 1'b0;
		modeSelect <= crt_mode_t'(~m);
		repeat (9000) @(posedge clk);
		@(negedge clk);
		`CHK(modeActive, m)
		`CHK(shutCnt, (shut && prot) ? 32'(SHUT_PULSE_CYC) : 32'h0)
		`CHK(pedLead >= PEDESTAL_CYC, 1'b1)
		`CHK(xferLen >= PD_XFER_CYC, 1'b1)
		`CHK(minVGap >= VSHIFT_CYC, 1'b1)
		`CHK(minPix >= HPIX_CYC && minPix < 32'h100, 1'b1)
		`CHK(rowCount, 32'h1)
		if (shut && prot)
			`CHK(integCycles >= expInteg, 1'b1)
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		srst = 1'b1;
		run = 1'b0;
		modeSelect = MODE_QUAD;
		shutterReq = 1'b0;
		exposureCycles = '0;
		protectionSupplyStable = 1'b0;
		substrateAbove3V = 1'b0;
		idReadDone = 1'b0;
		seed = 32'h1D85672E;
		badCount = 0;
		checked = 0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		`CHK(pins, crt_pins_t'(0))
		`CHK({biasEnable, frameActive, modeActive}, {2'b00, MODE_QUAD})
		`CHK(idCircuitEnable, 1'b1)
		@(posedge clk);
		srst <= 1'b0;
		run <= 1'b1;
		repeat (20) @(posedge clk);
		protectionSupplyStable <= 1'b1;
		repeat (20) @(negedge clk);
		`CHK({biasEnable, frameActive}, 2'b00)
		@(posedge clk);
		substrateAbove3V <= 1'b1;
		run <= 1'b0;
		wait_high(1'b0);
		@(posedge clk);
		idReadDone <= 1'b1;
		@(posedge clk);
		idReadDone <= 1'b0;
		repeat (6) @(negedge clk);
		`CHK(idCircuitEnable, 1'b0)
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			frame(i < 4 ? crt_mode_t'(i[1:0]) : crt_mode_t'(seed[1:0]), i != 2 && (i != 5 || seed[2]), i != 4,
				(i == 0) ? 24'h0 : {15'h0, seed[12:4]});
		end
		giveVerdict();
	end
endmodule
